// ==== hdl/pfs_bank.sv ====
`timescale 1ns/1ps
// How it works
// - a write sets low bit n only when mask bit 16+n is one.
// - a zero mask bit keeps the matching low bit, whatever data is written.
// - bits 31..16 are a write-only mask, read as zero, never stored.
// - pad c5 selector: 0 GPIO, 1 audio serial in, 2 mic data alternate.
module pfs_bank (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	// wishbone slave
	input  wire logic [7:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic        WE_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	// pad routing
	output logic      [63:0] PAD_ROUTE,
	output logic      [15:0] PAD_IS_GPIO,
	output logic             PAD_C5_AUDIO_IN_SEL,
	output logic             PAD_C5_MIC_ALT_SEL
);
	logic        ack;
	logic        next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [63:0] route;
	logic [63:0] next_route;
	logic [15:0] is_gpio;
	logic [15:0] next_is_gpio;
	logic        c5_audio;
	logic        next_c5_audio;
	logic        c5_mic;
	logic        next_c5_mic;

	logic        req;
	logic [3:0]  hit;
	logic [15:0] eff_mask;
	logic [63:0] q_all;
	logic [3:0]  c5_code;

	assign req = CYC_I & STB_I;

	always_comb begin
		hit[0] = (ADR_I[7:2] == pfs_pkg::PFS_OFS_GROUP2B_UPPER[7:2]);
		hit[1] = (ADR_I[7:2] == pfs_pkg::PFS_OFS_GROUP2C_LOWER[7:2]);
		hit[2] = (ADR_I[7:2] == pfs_pkg::PFS_OFS_GROUP2C_UPPER[7:2]);
		hit[3] = (ADR_I[7:2] == pfs_pkg::PFS_OFS_GROUP3A_LOWER[7:2]);
	end

	// a mask byte only counts when its lane and the data lane are both enabled
	always_comb begin
		eff_mask[7:0]  = (SEL_I[2] & SEL_I[0]) ? DAT_I[23:16] : 8'h00;
		eff_mask[15:8] = (SEL_I[3] & SEL_I[1]) ? DAT_I[31:24] : 8'h00;
	end

	pfs_wr_if wr_bus [4] ();

	genvar k;
	generate
		for (k = 0; k < pfs_pkg::PFS_NUM_REGS; k++) begin : g_reg
			// write lands on the edge at which the master samples ack
			assign wr_bus[k].wr_en = req & ack & WE_I & hit[k];
			assign wr_bus[k].data  = DAT_I[15:0];
			assign wr_bus[k].mask  = eff_mask;
			assign q_all[k*16 +: 16] = wr_bus[k].q;

			pfs_mask_reg u_reg (
				.clk    (MCLK),
				.resetn (RESETN),
				.wr     (wr_bus[k].store)
			);
		end
	endgenerate

	// bus answer: ack one cycle after the request, dropped the next cycle
	always_comb begin
		next_ack   = req & ~ack;
		next_rdata = pfs_pkg::PFS_UNMAPPED;
		if (req && !ack && !WE_I) begin
			for (int i = 0; i < pfs_pkg::PFS_NUM_REGS; i++) begin
				if (hit[i]) begin
					next_rdata = {pfs_pkg::PFS_MASK_READ, q_all[i*16 +: 16]};
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			ack   <= 1'b0;
			rdata <= pfs_pkg::PFS_UNMAPPED;
		end else begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	// pad routing: a reserved code must never reach a peripheral
	always_comb begin
		next_route   = 64'h0000_0000_0000_0000;
		next_is_gpio = 16'h0000;
		for (int p = 0; p < pfs_pkg::PFS_PADS; p++) begin
			if (q_all[p*4 +: 4] <= pfs_pkg::PFS_MAX_CODE[p*4 +: 4]) begin
				next_route[p*4 +: 4] = q_all[p*4 +: 4];
			end
			next_is_gpio[p] = (next_route[p*4 +: 4] == pfs_pkg::PFS_CODE_GPIO);
		end
	end

	assign c5_code = q_all[(pfs_pkg::PFS_C5_REG*4 + pfs_pkg::PFS_C5_FIELD)*4 +: 4];

	always_comb begin
		next_c5_audio = (c5_code == pfs_pkg::PFS_C5_AUDIO);
		next_c5_mic   = (c5_code == pfs_pkg::PFS_C5_MIC_ALT);
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			route    <= 64'h0000_0000_0000_0000;
			is_gpio  <= 16'hFFFF;
			c5_audio <= 1'b0;
			c5_mic   <= 1'b0;
		end else begin
			route    <= next_route;
			is_gpio  <= next_is_gpio;
			c5_audio <= next_c5_audio;
			c5_mic   <= next_c5_mic;
		end
	end

	assign DAT_O               = rdata;
	assign ACK_O               = ack;
	assign PAD_ROUTE           = route;
	assign PAD_IS_GPIO         = is_gpio;
	assign PAD_C5_AUDIO_IN_SEL = c5_audio;
	assign PAD_C5_MIC_ALT_SEL  = c5_mic;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	sequence s_request;
		req && !ack;
	endsequence

	sequence s_answer;
		ack ##1 !ack;
	endsequence

	bus_handshake_a: assert property (s_request |=> s_answer)
		else $error("ack not given for one cycle");

	mask_reads_zero_a: assert property (ack |-> (DAT_O[31:16] == 16'h0000))
		else $error("mask field read nonzero");

	c5_audio_route_a: assert property ((c5_code == 4'h1) |=> (PAD_C5_AUDIO_IN_SEL &&
		!PAD_C5_MIC_ALT_SEL && (PAD_ROUTE[39:36] == 4'h1)))
		else $error("pad c5 audio input not routed");

	c5_mic_route_a: assert property ((c5_code == 4'h2) |=> (PAD_C5_MIC_ALT_SEL &&
		!PAD_C5_AUDIO_IN_SEL && !PAD_IS_GPIO[9]))
		else $error("pad c5 mic alternate not routed");

	c5_gpio_route_a: assert property ((c5_code == 4'h0) |=> (PAD_IS_GPIO[9] &&
		!PAD_C5_AUDIO_IN_SEL && !PAD_C5_MIC_ALT_SEL))
		else $error("pad c5 not GPIO for code zero");

	reserved_gpio_a: assert property ((q_all[47:44] > 4'h0) |=>
		(PAD_ROUTE[47:44] == 4'h0 && PAD_IS_GPIO[11]))
		else $error("reserved code on pad c7 routed");

	reset_gpio_a: assert property (@(posedge MCLK) disable iff (1'b0)
		!RESETN |=> (PAD_IS_GPIO == 16'hFFFF && PAD_ROUTE == 64'h0 && !ACK_O))
		else $error("pads not GPIO after reset");

	write_lands_a: assert property ((req && ack && WE_I && hit[2] && (eff_mask[7:4] == 4'hF))
		|=> ##1 (c5_code == $past(DAT_I[7:4], 2)))
		else $error("written c5 code not stored");

	read_back_a: assert property ((s_request && !WE_I && hit[2]) |=>
		(DAT_O == {16'h0000, $past(q_all[47:32])}))
		else $error("selector read back wrong");

	zero_mask_keep_a: assert property ((req && ack && WE_I && (eff_mask == 16'h0000)) |=>
		$stable(q_all))
		else $error("selector changed under zero mask");

	reserved_a0_a: assert property ((q_all[51:48] > 4'h1) |=>
		(PAD_ROUTE[51:48] == 4'h0 && PAD_IS_GPIO[12]))
		else $error("reserved code on pad a0 routed");
endmodule

// ==== hdl/pfs_mask_reg.sv ====
`timescale 1ns/1ps
module pfs_mask_reg (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// write port
	pfs_wr_if.store  wr
);
	logic [15:0] q;
	logic [15:0] next_q;

	// mask is consumed here and never stored
	always_comb begin
		next_q = q;
		if (wr.wr_en) begin
			next_q = (wr.data & wr.mask) | (q & ~wr.mask);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= pfs_pkg::PFS_SEL_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign wr.q = q;

	masked_set_a: assert property (@(posedge clk) disable iff (!resetn)
		wr.wr_en |=> ((q & $past(wr.mask)) == ($past(wr.data) & $past(wr.mask))))
		else $error("masked bit not written");

	masked_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		wr.wr_en |=> ((q & ~$past(wr.mask)) == ($past(q) & ~$past(wr.mask))))
		else $error("unmasked bit changed");

	idle_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!wr.wr_en |=> $stable(q))
		else $error("selector changed without write");
endmodule

// ==== hdl/pfs_pkg.sv ====
package pfs_pkg;

	// register bus geometry
	localparam int          PFS_ADR_W     = 8;
	localparam int          PFS_DAT_W     = 32;
	localparam int          PFS_NUM_REGS  = 4;
	localparam int          PFS_HALF_W    = 16;
	localparam int          PFS_SEL_W     = 4;
	localparam int          PFS_PADS      = 16;
	localparam int          PFS_MASK_LSB  = 16;

	// byte offsets of the selection registers
	localparam logic [7:0]  PFS_OFS_GROUP2B_UPPER = 8'h2C;
	localparam logic [7:0]  PFS_OFS_GROUP2C_LOWER = 8'h30;
	localparam logic [7:0]  PFS_OFS_GROUP2C_UPPER = 8'h34;
	localparam logic [7:0]  PFS_OFS_GROUP3A_LOWER = 8'h40;

	// values after reset and fixed read values
	localparam logic [15:0] PFS_SEL_RESET  = 16'h0000;
	localparam logic [15:0] PFS_MASK_READ  = 16'h0000;
	localparam logic [31:0] PFS_UNMAPPED   = 32'h0000_0000;

	// selector codes
	localparam logic [3:0]  PFS_CODE_GPIO  = 4'h0;
	localparam logic [3:0]  PFS_C5_AUDIO   = 4'h1;
	localparam logic [3:0]  PFS_C5_MIC_ALT = 4'h2;

	// pad c5 sits in group 2c upper, field 1
	localparam int          PFS_C5_REG     = 2;
	localparam int          PFS_C5_FIELD   = 1;

	// highest assigned code per pad, nibble 4*reg+field
	// reg0: b4..b7, reg1: c0..c3, reg2: c4..c7, reg3: a0..a3
	localparam logic [63:0] PFS_MAX_CODE   = 64'h4441_0121_1112_2212;

endpackage

// ==== hdl/pfs_wr_if.sv ====
`timescale 1ns/1ps
interface pfs_wr_if;
	logic        wr_en;
	logic [15:0] data;
	logic [15:0] mask;
	logic [15:0] q;

	modport ctl (
		output wr_en,
		output data,
		output mask,
		input  q
	);
	modport store (
		input  wr_en,
		input  data,
		input  mask,
		output q
	);
endinterface

// ==== test/pfs_bank_tb.sv ====
`timescale 1ns/1ps
module pfs_bank_tb;
	logic        MCLK   = 1'b0;
	logic        RESETN = 1'b0;
	logic [7:0]  ADR_I  = 8'h00;
	logic [31:0] DAT_I  = 32'h0000_0000;
	logic [3:0]  SEL_I  = 4'hF;
	logic        WE_I   = 1'b0;
	logic        CYC_I  = 1'b0;
	logic        STB_I  = 1'b0;
	logic [31:0] DAT_O;
	logic        ACK_O;
	logic [63:0] PAD_ROUTE;
	logic [15:0] PAD_IS_GPIO;
	logic        PAD_C5_AUDIO_IN_SEL;
	logic        PAD_C5_MIC_ALT_SEL;
	int          n_mismatch = 0;
	int          cmp_count  = 0;

	always #4 MCLK = ~MCLK;

	pfs_bank i_dut (
		.MCLK                (MCLK),
		.RESETN              (RESETN),
		.ADR_I               (ADR_I),
		.DAT_I               (DAT_I),
		.SEL_I               (SEL_I),
		.WE_I                (WE_I),
		.CYC_I               (CYC_I),
		.STB_I               (STB_I),
		.DAT_O               (DAT_O),
		.ACK_O               (ACK_O),
		.PAD_ROUTE           (PAD_ROUTE),
		.PAD_IS_GPIO         (PAD_IS_GPIO),
		.PAD_C5_AUDIO_IN_SEL (PAD_C5_AUDIO_IN_SEL),
		.PAD_C5_MIC_ALT_SEL  (PAD_C5_MIC_ALT_SEL)
	);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; holds the request until ack, only the watchdog ends a wait
	task automatic wb(input logic [7:0] a, input logic we, input logic [3:0] s,
			input logic [31:0] d, output logic [31:0] q);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I  <= we;
		SEL_I <= s;
		ADR_I <= a;
		DAT_I <= d;
		do begin
			@(posedge MCLK);
		end while (ACK_O !== 1'b1);
		q = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		WE_I  <= 1'b0;
		@(posedge MCLK);
	endtask

	task automatic wrs(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, s, d, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wrs(a, 4'hF, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(a, 1'b0, 4'hF, 32'h0000_0000, q);
		chk({32'h0000_0000, q}, {32'h0000_0000, e});
	endtask

	// pad c5: gpio flag, routed code, audio select, mic select
	task automatic pads(input logic [6:0] e);
		chk({57'h0, PAD_IS_GPIO[9], PAD_ROUTE[39:36], PAD_C5_AUDIO_IN_SEL,
			PAD_C5_MIC_ALT_SEL}, {57'h0, e});
	endtask

	task automatic finish_test;
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge MCLK);
		RESETN <= 1'b1;
		@(posedge MCLK);
		chk(PAD_ROUTE, 64'h0);
		chk({48'h0, PAD_IS_GPIO}, {48'h0, 16'hFFFF});
		rchk(8'h2C, 32'h0000_0000);
		rchk(8'h30, 32'h0000_0000);
		rchk(8'h34, 32'h0000_0000);
		rchk(8'h40, 32'h0000_0000);
		wr(8'h34, 32'hFFFF_0010);
		rchk(8'h34, 32'h0000_0010);
		pads(7'b0_0001_10);
		// only bit 5 enabled: code becomes 3, which is unassigned
		wr(8'h34, 32'h0020_00FF);
		rchk(8'h34, 32'h0000_0030);
		pads(7'b1_0000_00);
		wr(8'h34, 32'h00F0_0020);
		rchk(8'h34, 32'h0000_0020);
		pads(7'b0_0010_01);
		wr(8'h34, 32'h0000_FFFF);
		rchk(8'h34, 32'h0000_0020);
		wr(8'h34, 32'h00F0_0000);
		rchk(8'h34, 32'h0000_0000);
		pads(7'b1_0000_00);
		// pad c7 has no alternate: code 5 is stored but routed as GPIO
		wr(8'h34, 32'hF000_5000);
		rchk(8'h34, 32'h0000_5000);
		wr(8'h30, 32'h0002_0003);
		rchk(8'h30, 32'h0000_0002);
		wr(8'h2C, 32'h0000_FFFF);
		rchk(8'h2C, 32'h0000_0000);
		wr(8'h40, 32'hFFFF_1234);
		rchk(8'h40, 32'h0000_1234);
		// mask lanes disabled: nothing may change
		wrs(8'h40, 4'h3, 32'hFFFF_0000);
		rchk(8'h40, 32'h0000_1234);
		// mask byte 2 with data byte 0 clears the low byte only
		wrs(8'h40, 4'h5, 32'h00FF_0000);
		rchk(8'h40, 32'h0000_1200);
		wr(8'h38, 32'hFFFF_FFFF);
		rchk(8'h38, 32'h0000_0000);
		chk(PAD_ROUTE, 64'h1200_0000_0002_0000);
		chk({48'h0, PAD_IS_GPIO}, {48'h0, 16'h3FEF});
		// second reset in mid-run clears every selector
		RESETN <= 1'b0;
		repeat (2) @(posedge MCLK);
		RESETN <= 1'b1;
		@(posedge MCLK);
		chk(PAD_ROUTE, 64'h0);
		chk({48'h0, PAD_IS_GPIO}, {48'h0, 16'hFFFF});
		rchk(8'h40, 32'h0000_0000);
		finish_test();
	end
endmodule
